// >>> rtl/quad_dac_serial_load_control.sv
`timescale 1ns/10ps
module quad_dac_serial_load_control (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic serial_in_shutdown_pin_in,
  input wire logic hardware_power_down_in,
  input wire logic async_clear_n_in,
  input wire logic converter_load_strobe_n_in,
  output logic [quad_dac_pkg::CODE_W-1:0] code_a_out,
  output logic [quad_dac_pkg::CODE_W-1:0] code_b_out,
  output logic [quad_dac_pkg::CODE_W-1:0] code_c_out,
  output logic [quad_dac_pkg::CODE_W-1:0] code_d_out,
  output logic [quad_dac_pkg::CHANNELS-1:0] channel_drive_en_out
);
  typedef logic [quad_dac_pkg::CHANNELS-1:0][quad_dac_pkg::CODE_W-1:0] bank_t;

  typedef struct packed {
    logic sclk_prev;
    logic cs_n_prev;
    logic [quad_dac_pkg::FRAME_BITS-1:0] shift;
    logic [quad_dac_pkg::CNT_W-1:0] cnt;
    bank_t in_reg;
    bank_t conv_reg;
    logic [quad_dac_pkg::CHANNELS-1:0] sw_down;
    logic [quad_dac_pkg::CHANNELS-1:0] drive_en;
  } state_s;

  state_s q;
  state_s d;

  logic [quad_dac_pkg::SYNC_W-1:0] pins;
  logic s_sclk;
  logic s_cs_n;
  logic s_ser_data;
  logic s_hw_down;
  logic s_clear_n;
  logic s_load_n;
  logic sclk_rise;
  logic cs_rise;
  logic frame_ok;
  logic [quad_dac_pkg::ADDR_W-1:0] frame_addr;
  logic shutdown_all_channels_bit;
  logic shutdown_selected_channel_bit;

  pin_sync #(
    .W(quad_dac_pkg::SYNC_W),
    .RST_VAL(quad_dac_pkg::SYNC_RST)
  ) u_pin_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in({sclk_in, cs_n_in, serial_in_shutdown_pin_in, hardware_power_down_in,
      async_clear_n_in, converter_load_strobe_n_in}),
    .sync_out(pins)
  );

  assign {s_sclk, s_cs_n, s_ser_data, s_hw_down, s_clear_n, s_load_n} = pins;
  assign sclk_rise = s_sclk & ~q.sclk_prev;
  assign cs_rise = s_cs_n & ~q.cs_n_prev;
  assign frame_ok = (q.cnt == quad_dac_pkg::CNT_FULL);
  // Field split of the received word
  assign frame_addr = q.shift[quad_dac_pkg::CHANNEL_SELECT_HI:quad_dac_pkg::CHANNEL_SELECT_LO];
  assign shutdown_all_channels_bit = q.shift[quad_dac_pkg::SHUTDOWN_ALL_CHANNELS_BIT];
  assign shutdown_selected_channel_bit = q.shift[quad_dac_pkg::SHUTDOWN_SELECTED_CHANNEL_BIT];

  always_comb
  begin
    d = q;
    d.sclk_prev = s_sclk;
    d.cs_n_prev = s_cs_n;
    if (sclk_rise && !s_cs_n)
    begin
      d.shift = {q.shift[quad_dac_pkg::FRAME_BITS-2:0], s_ser_data};
      if (q.cnt != quad_dac_pkg::CNT_FULL)
      begin
        d.cnt = q.cnt + quad_dac_pkg::CNT_ONE;
      end
    end
    if (cs_rise)
    begin
      d.cnt = quad_dac_pkg::CNT_ZERO;
      if (frame_ok)
      begin
        d.in_reg[frame_addr] = q.shift[quad_dac_pkg::DATA_MSB:quad_dac_pkg::DATA_LSB];
        if (shutdown_all_channels_bit == quad_dac_pkg::CMD_ACTIVE)
        begin
          d.sw_down = '1;
        end
        else if (shutdown_selected_channel_bit == quad_dac_pkg::CMD_ACTIVE)
        begin
          d.sw_down[frame_addr] = 1'b1;
        end
        else
        begin
          d.sw_down[frame_addr] = 1'b0;
        end
      end
    end
    if (!s_load_n)
    begin
      d.conv_reg = d.in_reg;
    end
    if (!s_clear_n)
    begin
      d.in_reg = '0;
      d.conv_reg = '0;
    end
    d.drive_en = ~(d.sw_down | {quad_dac_pkg::CHANNELS{s_hw_down}});
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      q <= '0;
      q.cs_n_prev <= quad_dac_pkg::CS_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  // Codes drive the ladders directly
  assign code_a_out = q.conv_reg[quad_dac_pkg::CH_A];
  assign code_b_out = q.conv_reg[quad_dac_pkg::CH_B];
  assign code_c_out = q.conv_reg[quad_dac_pkg::CH_C];
  assign code_d_out = q.conv_reg[quad_dac_pkg::CH_D];
  assign channel_drive_en_out = q.drive_en;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_shift_in;
    sclk_rise && !s_cs_n
      |=> q.shift == {$past(q.shift[quad_dac_pkg::FRAME_BITS-2:0]), $past(s_ser_data)};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("serial bit not shifted");

  property p_ignore_high;
    s_cs_n |=> q.shift == $past(q.shift);
  endproperty
  a_ignore_high: assert property (p_ignore_high) else $error("shift moved with cs high");

  property p_load_addr;
    cs_rise && frame_ok && s_clear_n
      |=> q.in_reg[$past(frame_addr)] == $past(q.shift[7:0]);
  endproperty
  a_load_addr: assert property (p_load_addr) else $error("input register not loaded");

  property p_all_down;
    cs_rise && frame_ok && !shutdown_all_channels_bit |=> q.sw_down == 4'hf ##1
      channel_drive_en_out == 4'h0;
  endproperty
  a_all_down: assert property (p_all_down) else $error("all-channel shutdown missed");

  property p_sel_down;
    cs_rise && frame_ok && shutdown_all_channels_bit && !shutdown_selected_channel_bit
      |=> q.sw_down[$past(frame_addr)] && q.in_reg[$past(frame_addr)] == $past(q.shift[7:0])
      || !$past(s_clear_n);
  endproperty
  a_sel_down: assert property (p_sel_down) else $error("selected shutdown missed");

  property p_drive_off;
    1'b1 |=> (channel_drive_en_out
      & (q.sw_down | {quad_dac_pkg::CHANNELS{$past(s_hw_down)}})) == '0;
  endproperty
  a_drive_off: assert property (p_drive_off) else $error("driver on in shutdown");

  property p_hw_hold;
    s_hw_down && s_clear_n && !cs_rise && (s_load_n || q.conv_reg == q.in_reg)
      |=> q.conv_reg == $past(q.conv_reg) ##1
      channel_drive_en_out == 4'h0 || !$past(s_hw_down);
  endproperty
  a_hw_hold: assert property (p_hw_hold) else $error("shutdown disturbed codes");

  property p_clear;
    !s_clear_n |=> q.in_reg == '0 && q.conv_reg == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not zero registers");

  property p_transparent;
    !s_load_n && s_clear_n |=> q.conv_reg == q.in_reg;
  endproperty
  a_transparent: assert property (p_transparent) else $error("converter not transparent");

  property p_stay_zero;
    q.in_reg == '0 && q.conv_reg == '0 && !(cs_rise && frame_ok) |=> q.conv_reg == '0;
  endproperty
  a_stay_zero: assert property (p_stay_zero) else $error("code left zero without load");

  property p_drop_short;
    cs_rise && !frame_ok && s_clear_n
      |=> q.in_reg == $past(q.in_reg) && q.sw_down == $past(q.sw_down);
  endproperty
  a_drop_short: assert property (p_drop_short) else $error("short frame was decoded");

  c_frame_load: cover property (cs_rise && frame_ok && shutdown_all_channels_bit
    && shutdown_selected_channel_bit);
  c_all_down: cover property (cs_rise && frame_ok && !shutdown_all_channels_bit);
  c_hw_down: cover property (s_hw_down ##1 !s_hw_down);
  c_both_down: cover property (cs_rise && frame_ok && !shutdown_all_channels_bit
    && !shutdown_selected_channel_bit);
endmodule : quad_dac_serial_load_control

// >>> rtl/quad_dac_pkg.sv
package quad_dac_pkg;
  localparam int unsigned CHANNELS = 4;
  localparam int unsigned CODE_W = 8;
  localparam int unsigned FRAME_BITS = 12;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned ADDR_W = 2;
  // Frame layout, first shifted bit is the top index
  localparam int unsigned CHANNEL_SELECT_HI = 11;
  localparam int unsigned CHANNEL_SELECT_LO = 10;
  localparam int unsigned SHUTDOWN_ALL_CHANNELS_BIT = 9;
  localparam int unsigned SHUTDOWN_SELECTED_CHANNEL_BIT = 8;
  localparam int unsigned DATA_MSB = 7;
  localparam int unsigned DATA_LSB = 0;
  localparam logic CMD_ACTIVE = 1'b0;
  localparam logic [CNT_W-1:0] CNT_FULL = 4'hC;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] CH_A = 2'h0;
  localparam logic [ADDR_W-1:0] CH_B = 2'h1;
  localparam logic [ADDR_W-1:0] CH_C = 2'h2;
  localparam logic [ADDR_W-1:0] CH_D = 2'h3;
  localparam int unsigned SYNC_W = 6;
  // Synchroniser reset: chip select and clear rest at their idle high level
  localparam logic [SYNC_W-1:0] SYNC_RST = 6'h12;
  localparam logic CS_IDLE = 1'b1;
endpackage : quad_dac_pkg

// >>> rtl/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_s;

  sync_s q;
  sync_s d;

  // Two flops per pin
  always_comb
  begin
    d.meta = async_in;
    d.stable = q.meta;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      q <= {RST_VAL, RST_VAL};
    end
    else
    begin
      q <= d;
    end
  end

  assign sync_out = q.stable;
endmodule : pin_sync

// >>> test/serial_master.sv
`timescale 1ns/10ps
module serial_master (
  input wire logic clk_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic data_out
);
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    data_out = 1'b0;
  end
  task automatic half();
    repeat (4) @(posedge clk_in);
    #1;
  endtask : half
  // Clock pulse with chip select high
  task automatic stray();
    half();
    sclk_out = 1'b1;
    half();
    sclk_out = 1'b0;
  endtask : stray
  // Low n bits of w, top bit first
  task automatic send(input logic [15:0] w, input int n);
    half();
    cs_n_out = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      half();
      sclk_out = 1'b0;
      data_out = w[i];
      half();
      sclk_out = 1'b1;
    end
    half();
    sclk_out = 1'b0;
    data_out = ~data_out;
    half();
    cs_n_out = 1'b1;
    half();
  endtask : send
endmodule : serial_master

// >>> test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk_in;
  logic rst_n_in;
  logic sclk, cs_n, ser_data, pd, clear_n, ld_n;
  logic [7:0] ca, cb, cc, cd;
  logic [3:0] en;
  int num_errors;
  int checked;
  serial_master host (.clk_in(clk_in), .sclk_out(sclk), .cs_n_out(cs_n), .data_out(ser_data));
  quad_dac_serial_load_control uut (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .sclk_in(sclk),
    .cs_n_in(cs_n),
    .serial_in_shutdown_pin_in(ser_data),
    .hardware_power_down_in(pd),
    .async_clear_n_in(clear_n),
    .converter_load_strobe_n_in(ld_n),
    .code_a_out(ca),
    .code_b_out(cb),
    .code_c_out(cc),
    .code_d_out(cd),
    .channel_drive_en_out(en)
  );
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : settle
  task automatic chk_codes(input logic [31:0] exp);
    checked++;
    if ({ca, cb, cc, cd} !== exp)
    begin
      num_errors++;
      $display("BAD %0t codes %h exp %h", $time, {ca, cb, cc, cd}, exp);
    end
  endtask : chk_codes
  task automatic chk_en(input logic [3:0] exp);
    checked++;
    if (en !== exp)
    begin
      num_errors++;
      $display("BAD %0t drive %h exp %h", $time, en, exp);
    end
  endtask : chk_en
  task automatic frame(input logic [15:0] w, input int n);
    host.send(w, n);
    settle(8);
  endtask : frame
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  initial
  begin
    rst_n_in = 1'b0;
    pd = 1'b0;
    clear_n = 1'b1;
    ld_n = 1'b0;
    num_errors = 0;
    checked = 0;
    settle(4);
    rst_n_in = 1'b1;
    settle(8);
    chk_codes(32'h0000_0000);
    chk_en(4'hf);
    for (int i = 0; i < 4; i++)
      frame({4'h0, i[1:0], 2'b11, 8'(i * 8'h55 + 8'h0f)}, 12);
    chk_codes(32'h0f64_b90e);
    frame(16'hc3aa, 16);
    chk_codes(32'haa64_b90e);
    repeat (3) host.stray();
    frame(16'h0355, 11);
    chk_codes(32'haa64_b90e);
    ld_n = 1'b1;
    frame(16'h0f99, 12);
    chk_codes(32'haa64_b90e);
    ld_n = 1'b0;
    settle(6);
    chk_codes(32'haa64_b999);
    frame(16'h065a, 12);
    chk_codes(32'haa5a_b999);
    chk_en(4'hd);
    frame(16'h0944, 12);
    chk_en(4'h0);
    frame(16'h075b, 12);
    chk_en(4'h2);
    frame(16'h0c33, 12);
    chk_en(4'h0);
    frame(16'h075b, 12);
    chk_en(4'h2);
    pd = 1'b1;
    settle(6);
    chk_en(4'h0);
    chk_codes(32'haa5b_4433);
    pd = 1'b0;
    settle(6);
    chk_en(4'h2);
    clear_n = 1'b0;
    settle(6);
    chk_codes(32'h0000_0000);
    clear_n = 1'b1;
    settle(4);
    chk_codes(32'h0000_0000);
    frame(16'h0b77, 12);
    chk_codes(32'h0000_7700);
    rst_n_in = 1'b0;
    settle(4);
    rst_n_in = 1'b1;
    settle(8);
    chk_codes(32'h0000_0000);
    chk_en(4'hf);
    give_verdict();
  end
endmodule : tb_top
